/* File: rtl/sar_ctrl_pkg.sv */
// Package: constants, states and carrier types of the conversion control
package sar_ctrl_pkg;
   localparam int RESULT_W = 8;
   localparam int PHASE_DIV = 8;
   localparam int PHASE_CNT_W = 3;
   localparam int SHIFT_LEN = 8;
   localparam int EXT_CLK_PER_CONV = 64;
   localparam int DONE_SET_CYCLES = 8;
   localparam int DONE_SET_CNT_W = 4;
   localparam int UPDATE_LEAD_CYCLES = 1;
   localparam int CLK_FREQ_HZ = 40000000;
   localparam int FREE_RUN_PULSE_NS = 300;
   localparam int FREE_RUN_PULSE_CYC =
      (FREE_RUN_PULSE_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
   localparam logic [7:0] RESULT_ZERO = 8'h00;
   localparam logic [7:0] RESULT_FULL = 8'hFF;
   localparam logic [2:0] PHASE_RESET = 3'h0;
   localparam logic [2:0] PHASE_LAST = 3'h7;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01,
      ST_SEARCH = 2'b10,
      ST_DONE = 2'b11
   } conv_state_t;

   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
   } bus_ctrl_t;

   typedef struct packed {
      logic [7:0] data;
      logic oe;
   } data_bus_t;
endpackage : sar_ctrl_pkg

/* File: rtl/phase_divider.sv */
// Module: divide-by-eight phase enable generator
`timescale 1ns/1ps
module phase_divider #(
   parameter int DIV = 8,
   parameter int CNT_W = 3
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // Control
   input wire logic clear_in,
   output logic tick_out
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   always_comb begin
      if (clear_in) begin
         cnt_d = '0;
      end else if (cnt_q == CNT_W'(DIV - 1)) begin
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign tick_out = !clear_in && (cnt_q == CNT_W'(DIV - 1));
endmodule : phase_divider

/* File: rtl/sar_adc_conversion_control.sv */
// Module: control logic of an 8-bit successive-approximation converter
//
// Summary of operation
// - Resolve MSB first, eight comparisons over sixty-four clock cycles.
// - Load result into output latch, then drive done low.
// - New start during a conversion aborts it and restarts.
// - Free-run: chip select low, done looped to write-start.
// - Write-start falling edge clears result register and shift chain.
// - Chip select and write-start both low hold device in reset.
// - Conversion starts one to eight clocks after a start input rises, nine to sixteen if no phase tick fell inside the strobe.
// - Start flop set clears chain, clears done flop, feeds entry flop.
// - Gated pulse clears start flop only once its set condition ends.
// - Marker leaving the chain loads result into output latches.
// - Completion latch sets done flop; pin is its inverse.
// - Sequencing runs at one eighth clock; done set lasts eight clocks.
// - With read held low, done still falls for eight clocks.
// - Free-run: falling done restarts, giving a short done pulse.
// - Chip select and read low clear done and drive the result.
// - Output result updates one clock before done asserts.
// - Negative input at or above positive yields all-zero code.
`timescale 1ns/1ps
module sar_adc_conversion_control #(
   parameter int RESULT_W = sar_ctrl_pkg::RESULT_W,
   parameter int SHIFT_LEN = sar_ctrl_pkg::SHIFT_LEN
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   // Bus control strobes, active low
   input wire logic cs_n_in,
   input wire logic wr_n_in,
   input wire logic rd_n_in,
   // Comparator: high when positive input is at or above trial level
   input wire logic comp_in,
   input wire logic vin_neg_ge_pos_in,
   // Trial word to the ladder
   output logic [RESULT_W-1:0] trial_out,
   output logic sample_out,
   // Result and done
   output logic [RESULT_W-1:0] data_out,
   output logic data_oe_out,
   output logic conversion_done_n_out
);
   sar_ctrl_pkg::bus_ctrl_t ctrl;
   sar_ctrl_pkg::conv_state_t state_q, state_d;
   logic start_flop_q, start_flop_d;
   logic wr_n_q, wr_n_d;
   logic token_entry_flop_q, token_entry_flop_d;
   logic [SHIFT_LEN-1:0] shift_q, shift_d;
   logic [RESULT_W-1:0] approximation_result_reg_q, approximation_result_reg_d;
   logic [RESULT_W-1:0] latch_q, latch_d;
   logic [RESULT_W-1:0] data_q, data_d;
   logic data_oe_q, data_oe_d;
   logic done_flop_q, done_flop_d;
   logic [3:0] done_set_q, done_set_d;
   logic [3:0] bit_idx_q, bit_idx_d;
   logic phase_tick;
   logic set_cond;
   logic wr_fall;
   logic start_clear_gate;
   logic result_load_gate;
   logic read_active;
   logic start_release;

   assign ctrl = '{cs_n: cs_n_in, wr_n: wr_n_in, rd_n: rd_n_in};
   assign set_cond = !ctrl.cs_n && !ctrl.wr_n;
   assign wr_fall = wr_n_q && !ctrl.wr_n;
   assign read_active = !ctrl.cs_n && !ctrl.rd_n;

   phase_divider #(
      .DIV(sar_ctrl_pkg::PHASE_DIV),
      .CNT_W(sar_ctrl_pkg::PHASE_CNT_W)
   ) u_phase (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .clear_in(1'b0),
      .tick_out(phase_tick)
   );

   // Gated pulse that may release the start flop
   assign start_clear_gate = phase_tick && token_entry_flop_q;
   // Release only once the set condition has ended; until then the
   // chain stays cleared, so a wide strobe just holds off the search
   assign start_release = start_clear_gate && start_flop_q && !set_cond;
   assign result_load_gate = phase_tick && (state_q == sar_ctrl_pkg::ST_SEARCH)
      && shift_q[SHIFT_LEN-1];

   always_comb begin
      state_d = state_q;
      start_flop_d = start_flop_q;
      wr_n_d = ctrl.wr_n;
      token_entry_flop_d = token_entry_flop_q;
      shift_d = shift_q;
      approximation_result_reg_d = approximation_result_reg_q;
      latch_d = latch_q;
      done_flop_d = done_flop_q;
      done_set_d = done_set_q;
      bit_idx_d = bit_idx_q;

      if (set_cond) begin
         start_flop_d = 1'b1;
      end else if (start_clear_gate && start_flop_q) begin
         start_flop_d = 1'b0;
      end

      case (state_q)
         sar_ctrl_pkg::ST_IDLE, sar_ctrl_pkg::ST_DONE: begin
            if (start_flop_q) begin
               state_d = sar_ctrl_pkg::ST_HOLD;
            end
         end
         sar_ctrl_pkg::ST_HOLD: begin
            if (phase_tick) begin
               token_entry_flop_d = 1'b1;
               if (token_entry_flop_q && !set_cond) begin
                  state_d = sar_ctrl_pkg::ST_SEARCH;
                  token_entry_flop_d = 1'b0;
                  shift_d = {{(SHIFT_LEN-1){1'b0}}, 1'b1};
                  bit_idx_d = 4'(RESULT_W - 1);
                  approximation_result_reg_d = '0;
                  approximation_result_reg_d[RESULT_W-1] = 1'b1;
               end
            end
         end
         sar_ctrl_pkg::ST_SEARCH: begin
            if (phase_tick) begin
               if (result_load_gate) begin
                  // Final bit decided on this step
                  latch_d = approximation_result_reg_q;
                  latch_d[0] = comp_in;
                  if (vin_neg_ge_pos_in) begin
                     latch_d = sar_ctrl_pkg::RESULT_ZERO;
                  end
                  state_d = sar_ctrl_pkg::ST_DONE;
                  done_set_d = 4'(sar_ctrl_pkg::DONE_SET_CYCLES);
               end else begin
                  shift_d = {shift_q[SHIFT_LEN-2:0], 1'b0};
                  approximation_result_reg_d[bit_idx_q[2:0]] = comp_in;
                  approximation_result_reg_d[bit_idx_q[2:0] - 3'h1] = 1'b1;
                  bit_idx_d = bit_idx_q - 4'h1;
               end
            end
         end
         default: begin
            state_d = sar_ctrl_pkg::ST_IDLE;
         end
      endcase

      // Done flop set one clock after the latch update
      if (done_set_q != 4'h0) begin
         done_set_d = done_set_q - 4'h1;
         done_flop_d = 1'b1;
      end

      // Held start flop or fresh falling strobe keeps the chain cleared;
      // the release step itself must not wipe the marker just loaded
      if ((start_flop_q && !start_release) || wr_fall) begin
         shift_d = '0;
         approximation_result_reg_d = '0;
         done_set_d = 4'h0;
         done_flop_d = 1'b0;
         state_d = sar_ctrl_pkg::ST_HOLD;
         if (state_q != sar_ctrl_pkg::ST_HOLD) begin
            token_entry_flop_d = 1'b0;
         end
      end else if (read_active && done_set_q == 4'h0) begin
         done_flop_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= sar_ctrl_pkg::ST_IDLE;
         start_flop_q <= 1'b0;
         wr_n_q <= 1'b1;
         token_entry_flop_q <= 1'b0;
         shift_q <= '0;
         approximation_result_reg_q <= '0;
         latch_q <= '0;
         done_flop_q <= 1'b0;
         done_set_q <= 4'h0;
         bit_idx_q <= 4'h0;
      end else begin
         state_q <= state_d;
         start_flop_q <= start_flop_d;
         wr_n_q <= wr_n_d;
         token_entry_flop_q <= token_entry_flop_d;
         shift_q <= shift_d;
         approximation_result_reg_q <= approximation_result_reg_d;
         latch_q <= latch_d;
         done_flop_q <= done_flop_d;
         done_set_q <= done_set_d;
         bit_idx_q <= bit_idx_d;
      end
   end

   // Output drive stage
   always_comb begin
      data_oe_d = read_active;
      // Output word follows the latch load itself, one clock ahead of done
      data_d = latch_d;
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         data_q <= '0;
         data_oe_q <= 1'b0;
      end else begin
         data_q <= data_d;
         data_oe_q <= data_oe_d;
      end
   end

   assign data_out = data_q;
   assign data_oe_out = data_oe_q && read_active;
   assign conversion_done_n_out = !done_flop_q;
   assign trial_out = approximation_result_reg_q;
   assign sample_out = (state_q == sar_ctrl_pkg::ST_SEARCH) && phase_tick;
endmodule : sar_adc_conversion_control

/* File: tb/analog_front_model.sv */
// Model: analog front end answering each trial word
`timescale 1ns/1ps
module analog_front_model (
   // Trial word and held input level
   input wire logic [7:0] trial_in,
   input wire logic [7:0] level_in,
   // Comparator answer
   output logic keep_out
);
   assign keep_out = level_in >= trial_in;
endmodule : analog_front_model

/* File: tb/sar_ctrl_assertions.sv */
// Checker: port assertions for the conversion control
`timescale 1ns/1ps
module sar_ctrl_checker (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic cs_n_in,
   input wire logic wr_n_in,
   input wire logic rd_n_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe_out,
   input wire logic conversion_done_n_out
);
   logic [6:0] cnt_q, cnt_d;
   logic seen_q, seen_d;
   logic [3:0] low_q, low_d;
   wire logic st = !cs_n_in && !wr_n_in;
   always_comb begin
      cnt_d = st ? 7'h00 : (cnt_q == 7'h7F ? cnt_q : cnt_q + 7'h01);
      seen_d = seen_q | st;
      low_d = conversion_done_n_out ? 4'h0 : (low_q == 4'hF ? low_q : low_q + 4'h1);
   end
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q <= 7'h00;
         seen_q <= 1'b0;
         low_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
         seen_q <= seen_d;
         low_q <= low_d;
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   property p_oe_off; (cs_n_in || rd_n_in)[*2] |-> !data_oe_out; endproperty
   a_oe_off: assert property (p_oe_off) else $error("outputs driven");
   property p_oe_on; (!cs_n_in && !rd_n_in)[*2] |-> data_oe_out; endproperty
   a_oe_on: assert property (p_oe_on) else $error("outputs floating");
   property p_hold;
      $fell(conversion_done_n_out) && wr_n_in |->
         (!conversion_done_n_out || !wr_n_in)[*8];
   endproperty
   a_hold: assert property (p_hold) else $error("done too short");
   property p_first; $fell(conversion_done_n_out) |-> $stable(data_out); endproperty
   a_first: assert property (p_first) else $error("data late");
   property p_clr; st |-> ##[1:4] conversion_done_n_out; endproperty
   a_clr: assert property (p_clr) else $error("done not cleared");
   property p_lat;
      $fell(conversion_done_n_out) |-> cnt_q >= 7'h40 && cnt_q <= 7'h60;
   endproperty
   a_lat: assert property (p_lat) else $error("bad latency");
   property p_rd;
      low_q >= 4'h7 && !conversion_done_n_out && !cs_n_in && !rd_n_in
         |=> conversion_done_n_out;
   endproperty
   a_rd: assert property (p_rd) else $error("read kept done");
   property p_idle; !seen_q |-> conversion_done_n_out; endproperty
   a_idle: assert property (p_idle) else $error("done without start");
   c_done: cover property ($fell(conversion_done_n_out));
   c_read: cover property (!cs_n_in && !rd_n_in && !conversion_done_n_out);
   c_free: cover property ($fell(conversion_done_n_out) && !cs_n_in);
endmodule : sar_ctrl_checker
bind sar_adc_conversion_control sar_ctrl_checker i_chk (.sys_clk_in(sys_clk_in),
   .resetn_in(resetn_in), .cs_n_in(cs_n_in), .wr_n_in(wr_n_in), .rd_n_in(rd_n_in),
   .data_out(data_out), .data_oe_out(data_oe_out),
   .conversion_done_n_out(conversion_done_n_out));

/* File: tb/sar_adc_conversion_control_tb.sv */
// Testbench: conversion control against a behavioural result model
`timescale 1ns/1ps
module sar_adc_conversion_control_tb;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, neg = 1'b0, free_run = 1'b0, cs_idle = 1'b1;
   logic comp, sample, oe, done_n;
   logic [7:0] level = 8'h00;
   logic [7:0] trial, data;
   int n_fail = 0;
   int num_checks = 0;
   int seed = 32'hd0fa50ff;
   int n;
   int s;
   int exp_q[$];
   always #12.5 sys_clk_in = ~sys_clk_in;
   analog_front_model i_afe (.trial_in(trial), .level_in(level), .keep_out(comp));
   sar_adc_conversion_control i_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .cs_n_in(cs_n), .wr_n_in(wr_n & (done_n | ~free_run)), .rd_n_in(rd_n),
      .comp_in(comp), .vin_neg_ge_pos_in(neg), .trial_out(trial), .sample_out(sample),
      .data_out(data), .data_oe_out(oe), .conversion_done_n_out(done_n));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   // Start strobe, w cycles wide; wide strobes hold the search in reset
   task automatic start(input int w);
      @(negedge sys_clk_in);
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (w) @(negedge sys_clk_in);
      cs_n = cs_idle;
      wr_n = 1'b1;
   endtask : start
   task automatic wait_done;
      n = 0;
      s = 0;
      while (done_n !== 1'b0 && n < 200) begin
         @(negedge sys_clk_in);
         n++;
         s += int'(sample);
      end
      check({7'h00, n >= 64 && n <= 96}, 8'h01);
      check(8'(s), 8'h08);
   endtask : wait_done
   task automatic read(input logic [7:0] exp);
      @(negedge sys_clk_in);
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      check({7'h00, oe}, 8'h01);
      check(data, exp);
      check({7'h00, done_n}, 8'h01);
      cs_n = cs_idle;
      rd_n = 1'b1;
      repeat (2) @(negedge sys_clk_in);
      check({7'h00, oe}, 8'h00);
   endtask : read
   task automatic conv(input logic [7:0] v, input logic ng, input int w);
      level = v;
      neg = ng;
      exp_q.push_back(ng ? 0 : int'(v));
      start(w);
      wait_done();
      repeat (10) @(negedge sys_clk_in);
      read(8'(exp_q.pop_front()));
   endtask : conv
   initial begin
      repeat (20) @(negedge sys_clk_in);
      resetn_in = 1'b1;
      repeat (30) @(negedge sys_clk_in);
      check({7'h00, done_n}, 8'h01);
      conv(8'hFF, 1'b0, 1);
      conv(8'h00, 1'b0, 1);
      conv(8'hA5, 1'b1, 12);
      for (int i = 0; i < 8; i++) begin
         conv(8'($random(seed)), ($random(seed) & 3) == 0, 1 + ($unsigned($random(seed)) % 9));
      end
      level = 8'h3C;
      start(1);
      repeat (30) @(negedge sys_clk_in);
      conv(8'hC3, 1'b0, 2);
      cs_idle = 1'b0;
      cs_n = 1'b0;
      rd_n = 1'b0;
      level = 8'h5A;
      start(1);
      wait_done();
      repeat (8) begin
         check({7'h00, done_n}, 8'h00);
         @(negedge sys_clk_in);
      end
      check(data, 8'h5A);
      check({7'h00, done_n}, 8'h01);
      rd_n = 1'b1;
      level = 8'h77;
      free_run = 1'b1;
      start(1);
      n = 0;
      repeat (400) begin
         @(negedge sys_clk_in);
         n += done_n ? 0 : 1;
      end
      check({7'h00, n >= 3 && n <= 24}, 8'h01);
      free_run = 1'b0;
      repeat (100) @(negedge sys_clk_in);
      check({7'h00, done_n}, 8'h00);
      read(8'h77);
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      n_fail++;
      end_sim();
   end
endmodule : sar_adc_conversion_control_tb
